/* fprd_pkg.sv */
// Shared constants and types for the floppy result and parameter decoder.
`default_nettype none
package fprd_pkg;
  // Command opcodes, compared on the low five bits of the first byte.
  localparam logic [4:0] OP_READ    = 5'h06;
  localparam logic [4:0] OP_WRITE   = 5'h05;
  localparam logic [4:0] OP_VERIFY  = 5'h16;
  localparam logic [4:0] OP_FORMAT  = 5'h0d;
  localparam logic [4:0] OP_SEEK    = 5'h0f;
  localparam logic [4:0] OP_RECAL   = 5'h07;
  localparam logic [4:0] OP_SENSE   = 5'h08;
  localparam logic [4:0] OP_SPECIFY = 5'h03;
  localparam logic [4:0] OP_CONFIG  = 5'h13;
  localparam logic [4:0] OP_PERP    = 5'h12;
  // Parameter byte positions, the opcode byte being position zero.
  localparam logic [3:0] P_DRV  = 4'h1;
  localparam logic [3:0] P_CYL  = 4'h2;
  localparam logic [3:0] P_N    = 4'h5;
  localparam logic [3:0] P_DTL  = 4'h8;
  localparam logic [3:0] P_FN   = 4'h2;
  localparam logic [3:0] P_FSC  = 4'h3;
  localparam logic [3:0] P_FILL = 4'h5;
  localparam logic [3:0] P_CFG  = 4'h2;
  // Bit positions inside command and parameter bytes.
  localparam int B_EC    = 7;
  localparam int B_REL   = 7;
  localparam int B_DIR   = 6;
  localparam int B_FIFO_ENABLE_LOW = 5;
  localparam int B_PERP  = 2;
  localparam int B_WRDIR = 0;
  // Parameter and result byte counts.
  localparam logic [3:0] N_PXFER = 4'h8;
  localparam logic [3:0] N_PFMT  = 4'h5;
  localparam logic [3:0] N_PSEEK = 4'h2;
  localparam logic [3:0] N_PCFG  = 4'h3;
  localparam logic [3:0] N_PONE  = 4'h1;
  localparam logic [3:0] N_PZERO = 4'h0;
  localparam logic [2:0] N_RXFER = 3'h7;
  localparam logic [2:0] N_RSNS  = 3'h2;
  localparam int         RES_DEPTH = 7;
  // Status byte values, reset values and the size-code-zero sector length.
  localparam logic [7:0]  ST0_INVALID = 8'h80;
  localparam logic [7:0]  ST0_SEEKEND = 8'h20;
  localparam logic        FIFO_ENABLE_LOW_RST   = 1'h1;
  localparam logic [15:0] N0_BYTES    = 16'h0080;
  typedef enum logic [2:0] {
    CL_XFER, CL_FORMAT, CL_SEEK, CL_SENSE, CL_CONFIG, CL_PERP, CL_OTHER
  } fprd_cls_t;
endpackage
`default_nettype wire

/* fprd_cmd_decode.sv */
// Opcode decoder: validity, class and parameter byte count of a command.
`default_nettype none
module fprd_cmd_decode
  import fprd_pkg::*;
(
  input  wire logic [7:0] opByte,
  output logic            valid,
  output fprd_cls_t       cls,
  output logic [3:0]      paramCnt
);
  // Packs valid, class and parameter count for one opcode.
  function automatic logic [7:0] decode(input logic [4:0] op);
    case (op)
      OP_READ, OP_WRITE, OP_VERIFY:
        decode = {1'b1, CL_XFER, N_PXFER};
      OP_FORMAT:  decode = {1'b1, CL_FORMAT, N_PFMT};
      OP_SEEK:    decode = {1'b1, CL_SEEK, N_PSEEK};
      OP_RECAL:   decode = {1'b1, CL_OTHER, N_PONE};
      OP_SPECIFY: decode = {1'b1, CL_CONFIG, N_PSEEK};
      OP_SENSE:   decode = {1'b1, CL_SENSE, N_PZERO};
      OP_CONFIG:  decode = {1'b1, CL_CONFIG, N_PCFG};
      OP_PERP:    decode = {1'b1, CL_PERP, N_PONE};
      default:    decode = {1'b0, CL_OTHER, N_PZERO};
    endcase
  endfunction

  logic [7:0] dec;

  // Split the packed decode into its fields; a call result cannot be sliced.
  always_comb begin
    dec      = decode(opByte[4:0]);
    valid    = dec[7];
    cls      = fprd_cls_t'(dec[6:4]);
    paramCnt = dec[3:0];
  end
endmodule
`default_nettype wire

/* fprd_sector_gate.sv */
// Byte gating of a short sector against the programmed length.
`default_nettype none
module fprd_sector_gate
  import fprd_pkg::*;
(
  input  wire logic [7:0]  sizeCode,
  input  wire logic [7:0]  shortLen,
  input  wire logic [15:0] byteIdx,
  output logic             beyondLimit,
  output logic [15:0]      sectorBytes
);
  // The whole sector length feeds the CRC, whatever the limit, for size codes 0 through 7; above 7 it is zero.
  // full sector CRC
  always_comb begin
    sectorBytes = (sizeCode > 8'h07) ? 16'h0000 : N0_BYTES << sizeCode[2:0];
    beyondLimit = (sizeCode == 8'h00) && (byteIdx >= {8'h00, shortLen});
  end
endmodule
`default_nettype wire

/* fprd_result_param.sv */
// Command byte intake, parameter capture and result phase handshake.
`default_nettype none
// Notes on behaviour
// - Result phase starts when the interrupt output is raised; sense results are offered with it cleared.
// - Result bytes read only while request and toward-host both set.
// - After last result: request set, toward-host clear, busy clear.
// - First byte checked as a valid opcode, then parameters collected.
// - Invalid opcode raises interrupt; sense then returns invalid status.
// - Cylinder is an unsigned byte, zero through 255.
// - Relative seek steps out when direction is 0, in when 1.
// - Drive code 00 selects drive 0; code 01 is unimplemented.
// - Size code zero means 128 bytes, limited by short length.
// - Read: bytes past short length come off disk, not to host.
// - Write: bytes past short length are written as zeros.
// - Sector CRC covers the whole actual sector.
// - Verify count mode turns short length into sectors per track.
// - Active-low FIFO enable; disabled after reset.
// - Perpendicular flags set to 1 mark perpendicular drives.
// - Format writes the fill byte into every data field.
// - Bytes written only while request set and toward-host clear.
// - Request cleared after each write until the byte is handled.
module fprd_result_param
  import fprd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        hostWrStb,
  input  wire logic [7:0]  hostWrData,
  input  wire logic        hostRdStb,
  output logic      [7:0]  hostRdData_r,
  output logic             hostServiceRequestFlag_r,
  output logic             transferTowardHostFlag_r,
  output logic             commandBusyFlag_r,
  output logic             floppyIrqOut_r,
  output logic             execStart_r,
  output fprd_cls_t        execKind_r,
  output logic             xferWrite_r,
  input  wire logic        execDone,
  input  wire logic        execResWr,
  input  wire logic [7:0]  execResData,
  output logic      [7:0]  cylinder_r,
  output logic             relativeSeek_r,
  output logic             stepInward_r,
  output logic      [1:0]  driveSelectBits_r,
  output logic             drive1Unimpl_r,
  output logic      [7:0]  sizeCode_r,
  output logic      [7:0]  shortSectorLength_r,
  output logic             verifyCountMode_r,
  output logic      [7:0]  sectorsPerTrack_r,
  output logic             fifoEnableLow_r,
  output logic      [1:0]  perpendicularDriveFlags_r,
  output logic      [7:0]  fillByte_r,
  input  wire logic [15:0] dataByteIdx,
  input  wire logic [7:0]  dataByteIn,
  output logic             hostPass_r,
  output logic      [7:0]  diskByte_r,
  output logic      [15:0] crcLen_r
);
  typedef enum logic [2:0] {
    S_WAITW, S_PROC, S_EXEC, S_RES, S_RESGAP
  } fprd_state_t;

  fprd_state_t state_r, state_nxt;
  logic [3:0]  idx_r, idx_nxt, need_r, need_nxt;
  logic [2:0]  resIdx_r, resIdx_nxt, resCnt_r, resCnt_nxt;
  logic [2:0]  resWa_r, resWa_nxt;
  logic [7:0]  byte_r, byte_nxt;
  logic [7:0]  st0_r, st0_nxt;
  logic        pend_r, pend_nxt;
  logic [7:0]  resMem [RES_DEPTH];
  logic        resWe;
  logic [2:0]  resWaddr;
  logic [7:0]  resWd;
  logic        decValid;
  fprd_cls_t   decCls;
  logic [3:0]  decCnt;
  logic        beyond;
  logic [15:0] secBytes;
  logic [7:0]  rdData_nxt, cyl_nxt, sl_nxt, sz_nxt, spt_nxt, fill_nxt;
  logic        rqm_nxt, dio_nxt, busy_nxt, irq_nxt, start_nxt;
  logic        rel_nxt, dir_nxt, ec_nxt, fifo_enable_low_nxt, wr_nxt;
  logic [1:0]  ds_nxt, perp_nxt;
  fprd_cls_t   kind_nxt;
  logic        dispatch;

  fprd_cmd_decode u_dec (
    .opByte   (byte_r),
    .valid    (decValid),
    .cls      (decCls),
    .paramCnt (decCnt)
  );

  fprd_sector_gate u_gate (
    .sizeCode    (sizeCode_r),
    .shortLen    (shortSectorLength_r),
    .byteIdx     (dataByteIdx),
    .beyondLimit (beyond),
    .sectorBytes (secBytes)
  );

  // Sequencer: byte intake, parameter capture, execution and results.
  always_comb begin
    state_nxt  = state_r;
    idx_nxt    = idx_r;
    need_nxt   = need_r;
    resIdx_nxt = resIdx_r;
    resCnt_nxt = resCnt_r;
    resWa_nxt  = resWa_r;
    byte_nxt   = byte_r;
    st0_nxt    = st0_r;
    pend_nxt   = pend_r;
    busy_nxt   = commandBusyFlag_r;
    irq_nxt    = floppyIrqOut_r;
    start_nxt  = 1'b0;
    kind_nxt   = execKind_r;
    wr_nxt     = xferWrite_r;
    cyl_nxt    = cylinder_r;
    rel_nxt    = relativeSeek_r;
    dir_nxt    = stepInward_r;
    ds_nxt     = driveSelectBits_r;
    sz_nxt     = sizeCode_r;
    sl_nxt     = shortSectorLength_r;
    ec_nxt     = verifyCountMode_r;
    fifo_enable_low_nxt  = fifoEnableLow_r;
    perp_nxt   = perpendicularDriveFlags_r;
    fill_nxt   = fillByte_r;
    resWe      = 1'b0;
    resWaddr   = 3'h0;
    resWd      = 8'h00;
    dispatch   = 1'b0;
    case (state_r)
      S_WAITW: begin
        // no new command until results drained
        if (hostWrStb) begin
          byte_nxt  = hostWrData;
          state_nxt = S_PROC;
        end
      end
      S_PROC: begin
        state_nxt = S_WAITW;
        if (idx_r == 4'h0) begin
          if (!decValid) begin
            pend_nxt = 1'b1;
            st0_nxt  = ST0_INVALID;
            irq_nxt  = 1'b1;
          end else begin
            busy_nxt = 1'b1;
            kind_nxt = decCls;
            wr_nxt   = byte_r[B_WRDIR];
            need_nxt = decCnt;
            idx_nxt  = 4'h1;
            if (byte_r[4:0] == OP_VERIFY) begin
              ec_nxt = byte_r[B_EC];
            end else if (decCls == CL_XFER) begin
              ec_nxt = 1'b0;
            end
            if (decCls == CL_SEEK) begin
              rel_nxt = byte_r[B_REL];
              dir_nxt = byte_r[B_DIR];
            end
            dispatch = (decCnt == 4'h0);
          end
        end else begin
          idx_nxt  = idx_r + 4'h1;
          dispatch = (idx_r == need_r);
          if (idx_r == P_DRV && execKind_r != CL_CONFIG) begin
            if (execKind_r == CL_PERP) begin
              perp_nxt = byte_r[B_PERP+1:B_PERP];
            end else begin
              ds_nxt = byte_r[1:0];
            end
          end
          case (execKind_r)
            CL_XFER: begin
              if (idx_r == P_CYL) cyl_nxt = byte_r;
              // size code zero selects short length
              if (idx_r == P_N) sz_nxt = byte_r;
              if (idx_r == P_DTL) sl_nxt = byte_r;
            end
            CL_FORMAT: begin
              if (idx_r == P_FN) sz_nxt = byte_r;
              if (idx_r == P_FSC) sl_nxt = byte_r;
              if (idx_r == P_FILL) fill_nxt = byte_r;
            end
            CL_SEEK: begin
              if (idx_r == P_CYL) cyl_nxt = byte_r;
            end
            CL_CONFIG: begin
              if (need_r == N_PCFG && idx_r == P_CFG) begin
                fifo_enable_low_nxt = byte_r[B_FIFO_ENABLE_LOW];
              end
            end
            default: ;
          endcase
        end
        if (dispatch) begin
          idx_nxt = 4'h0;
          case (decValid && idx_r == 4'h0 ? decCls : execKind_r)
            CL_SENSE: begin
              // Sense answers the pending cause and clears it.
              resWe      = 1'b1;
              resWaddr   = 3'h0;
              resWd      = st0_r;
              resWa_nxt  = 3'h1;
              resIdx_nxt = 3'h0;
              resCnt_nxt = N_RSNS;
              pend_nxt   = 1'b0;
              irq_nxt    = 1'b0;
              st0_nxt    = ST0_INVALID;
              state_nxt  = S_RESGAP;
            end
            CL_CONFIG, CL_PERP: begin
              busy_nxt = 1'b0;
            end
            default: begin
              start_nxt = 1'b1;
              resWa_nxt = 3'h0;
              state_nxt = S_EXEC;
            end
          endcase
        end
      end
      S_EXEC: begin
        if (execResWr && resWa_r < N_RXFER) begin
          resWe     = 1'b1;
          resWaddr  = resWa_r;
          resWd     = execResData;
          resWa_nxt = resWa_r + 3'h1;
        end
        if (execDone) begin
          irq_nxt = 1'b1;
          if (execKind_r == CL_SEEK || execKind_r == CL_OTHER) begin
            pend_nxt  = 1'b1;
            st0_nxt   = ST0_SEEKEND | {6'h00, driveSelectBits_r};
            busy_nxt  = 1'b0;
            state_nxt = S_WAITW;
          end else begin
            resIdx_nxt = 3'h0;
            resCnt_nxt = N_RXFER;
            state_nxt  = S_RES;
          end
        end
      end
      S_RES: begin
        // byte offered with both flags set
        if (hostRdStb) begin
          irq_nxt    = 1'b0;
          resIdx_nxt = resIdx_r + 3'h1;
          if (resIdx_r + 3'h1 == resCnt_r) begin
            busy_nxt  = 1'b0;
            state_nxt = S_WAITW;
          end else begin
            state_nxt = S_RESGAP;
          end
        end
      end
      S_RESGAP: begin
        state_nxt = S_RES;
      end
      default: state_nxt = S_WAITW;
    endcase
    // request low while a byte is handled
    rqm_nxt = (state_nxt == S_WAITW) || (state_nxt == S_RES);
    dio_nxt = (state_nxt == S_RES) || (state_nxt == S_RESGAP);
    // The index passes the last slot after the final read; show zero then.
    rdData_nxt = (resIdx_nxt < N_RXFER) ? resMem[resIdx_nxt] : 8'h00;
    spt_nxt = ec_nxt ? sl_nxt : 8'h00;
  end

  // Result byte store, written by the sense path or the execution engine.
  always_ff @(posedge clk) begin
    if (resWe) begin
      resMem[resWaddr] <= resWd;
    end
  end

  // Sequencer and parameter registers.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r                   <= S_WAITW;
      idx_r                     <= 4'h0;
      need_r                    <= 4'h0;
      resIdx_r                  <= 3'h0;
      resCnt_r                  <= 3'h0;
      resWa_r                   <= 3'h0;
      byte_r                    <= 8'h00;
      st0_r                     <= ST0_INVALID;
      pend_r                    <= 1'b0;
      hostRdData_r              <= 8'h00;
      hostServiceRequestFlag_r  <= 1'b1;
      transferTowardHostFlag_r  <= 1'b0;
      commandBusyFlag_r         <= 1'b0;
      floppyIrqOut_r            <= 1'b0;
      execStart_r               <= 1'b0;
      execKind_r                <= CL_OTHER;
      xferWrite_r               <= 1'b0;
      cylinder_r                <= 8'h00;
      relativeSeek_r            <= 1'b0;
      stepInward_r              <= 1'b0;
      driveSelectBits_r         <= 2'h0;
      drive1Unimpl_r            <= 1'b0;
      sizeCode_r                <= 8'h00;
      shortSectorLength_r       <= 8'hff;
      verifyCountMode_r         <= 1'b0;
      sectorsPerTrack_r         <= 8'h00;
      fifoEnableLow_r           <= FIFO_ENABLE_LOW_RST;
      perpendicularDriveFlags_r <= 2'h0;
      fillByte_r                <= 8'h00;
    end else begin
      state_r                   <= state_nxt;
      idx_r                     <= idx_nxt;
      need_r                    <= need_nxt;
      resIdx_r                  <= resIdx_nxt;
      resCnt_r                  <= resCnt_nxt;
      resWa_r                   <= resWa_nxt;
      byte_r                    <= byte_nxt;
      st0_r                     <= st0_nxt;
      pend_r                    <= pend_nxt;
      hostRdData_r              <= rdData_nxt;
      hostServiceRequestFlag_r  <= rqm_nxt;
      transferTowardHostFlag_r  <= dio_nxt;
      commandBusyFlag_r         <= busy_nxt;
      floppyIrqOut_r            <= irq_nxt;
      execStart_r               <= start_nxt;
      execKind_r                <= kind_nxt;
      xferWrite_r               <= wr_nxt;
      cylinder_r                <= cyl_nxt;
      relativeSeek_r            <= rel_nxt;
      stepInward_r              <= dir_nxt;
      driveSelectBits_r         <= ds_nxt;
      drive1Unimpl_r            <= (ds_nxt != 2'h0);
      sizeCode_r                <= sz_nxt;
      shortSectorLength_r       <= sl_nxt;
      verifyCountMode_r         <= ec_nxt;
      sectorsPerTrack_r         <= spt_nxt;
      fifoEnableLow_r           <= fifo_enable_low_nxt;
      perpendicularDriveFlags_r <= perp_nxt;
      fillByte_r                <= fill_nxt;
    end
  end

  // Data path gating; one cycle late, so the engine must pipeline to match.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hostPass_r <= 1'b0;
      diskByte_r <= 8'h00;
      crcLen_r   <= 16'h0000;
    end else begin
      hostPass_r <= !xferWrite_r && !beyond;
      diskByte_r <= (execKind_r == CL_FORMAT) ? fillByte_r :
                    (beyond ? 8'h00 : dataByteIn);
      crcLen_r   <= secBytes;
    end
  end

  // A result byte on offer always shows both flags set.
  res_flags_a: assert property (@(posedge clk) disable iff (!resetn)
    state_r == S_RES |-> hostServiceRequestFlag_r && transferTowardHostFlag_r)
    else $error("result byte offered without both flags");
  last_read_a: assert property (@(posedge clk) disable iff (!resetn)
    state_r == S_RES && hostRdStb && resIdx_r + 3'h1 == resCnt_r |=>
    hostServiceRequestFlag_r && !transferTowardHostFlag_r &&
    !commandBusyFlag_r)
    else $error("flags wrong after last result byte");
  wr_gap_a: assert property (@(posedge clk) disable iff (!resetn)
    state_r == S_WAITW && hostWrStb |=> !hostServiceRequestFlag_r)
    else $error("request not cleared after host write");
  rd_gap_a: assert property (@(posedge clk) disable iff (!resetn)
    state_r == S_RES && hostRdStb && resIdx_r + 3'h1 != resCnt_r |=>
    !hostServiceRequestFlag_r ##1 hostServiceRequestFlag_r)
    else $error("request not cleared between result bytes");
  res_irq_a: assert property (@(posedge clk) disable iff (!resetn)
    state_r == S_EXEC && execDone && execKind_r == CL_XFER |=>
    floppyIrqOut_r && transferTowardHostFlag_r)
    else $error("result phase began without interrupt");
  bad_op_a: assert property (@(posedge clk) disable iff (!resetn)
    state_r == S_PROC && idx_r == 4'h0 && !decValid |=>
    floppyIrqOut_r && !commandBusyFlag_r)
    else $error("invalid opcode did not interrupt");
  busy_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    state_r == S_EXEC || state_r == S_RESGAP |-> commandBusyFlag_r)
    else $error("busy dropped before results were read");
  wr_idle_a: assert property (@(posedge clk) disable iff (!resetn)
    hostServiceRequestFlag_r && !transferTowardHostFlag_r |->
    state_r == S_WAITW)
    else $error("write state shown while not accepting");
  fifo_rst_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(resetn) |-> fifoEnableLow_r)
    else $error("FIFO not disabled after reset");
endmodule
`default_nettype wire

/* fprd_host_model.sv */
// Host stand-in: polls the request flags and moves single bytes.
`default_nettype none
module fprd_host_model (
  input  wire logic       clk,
  input  wire logic       host_service_request_flag,
  input  wire logic       transfer_toward_host_flag,
  input  wire logic [7:0] rdData,
  output var logic        wrStb,
  output var logic [7:0]  wrData,
  output var logic        rdStb
);
  timeunit 1ns;
  timeprecision 1ps;
  int stalls = 0;

  // Strobes idle low from time zero.
  initial begin
    wrStb = 1'b0;
    rdStb = 1'b0;
    wrData = 8'h00;
  end

  task automatic waitFlags(input logic toHost);
    int n;
    n = 0;
    while (!(host_service_request_flag === 1'b1 && transfer_toward_host_flag === toHost) && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n >= 400) stalls++;
  endtask

  // The extra edge lets the request flag drop before the next poll.
  task automatic wrByte(input logic [7:0] b);
    waitFlags(1'b0);
    wrData = b;
    wrStb = 1'b1;
    @(negedge clk);
    wrStb = 1'b0;
    wrData = ~b;
    @(negedge clk);
  endtask

  // each result byte is read in turn.
  task automatic rdByte(output logic [7:0] b);
    waitFlags(1'b1);
    b = rdData;
    rdStb = 1'b1;
    @(negedge clk);
    rdStb = 1'b0;
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

/* floppy_result_and_param_decode_test.sv */
// Self-checking bench: host and engine stand-ins around the decoder.
`default_nettype none
module floppy_result_and_param_decode_test
  import fprd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        resetn, wrStb, rdStb, host_service_request_flag, transfer_toward_host_flag, busy, irq, start, xw;
  logic        done, resWr, rel, inw, d1u, ec, fel, pass;
  logic [7:0]  wrData, rdData, resData, cyl, sz, sl, spt, fill, din, dbyte;
  logic [1:0]  ds, perp;
  logic [15:0] idx, crc;
  fprd_cls_t   kind;
  logic [7:0]  pb [9];
  logic [7:0]  expQ [$];
  int          seed = 42;
  int          miscompares = 0;
  int          compares = 0;

  // Free-running 200 MHz clock.
  always #2.5 clk = ~clk;

  fprd_result_param fprd_result_param_i (
    .clk(clk), .resetn(resetn), .hostWrStb(wrStb), .hostWrData(wrData),
    .hostRdStb(rdStb), .hostRdData_r(rdData),
    .hostServiceRequestFlag_r(host_service_request_flag), .transferTowardHostFlag_r(transfer_toward_host_flag),
    .commandBusyFlag_r(busy), .floppyIrqOut_r(irq), .execStart_r(start),
    .execKind_r(kind), .xferWrite_r(xw), .execDone(done),
    .execResWr(resWr), .execResData(resData), .cylinder_r(cyl),
    .relativeSeek_r(rel), .stepInward_r(inw), .driveSelectBits_r(ds),
    .drive1Unimpl_r(d1u), .sizeCode_r(sz), .shortSectorLength_r(sl),
    .verifyCountMode_r(ec), .sectorsPerTrack_r(spt),
    .fifoEnableLow_r(fel), .perpendicularDriveFlags_r(perp),
    .fillByte_r(fill), .dataByteIdx(idx), .dataByteIn(din),
    .hostPass_r(pass), .diskByte_r(dbyte), .crcLen_r(crc)
  );
  fprd_host_model fprd_host_model_i (
    .clk(clk), .host_service_request_flag(host_service_request_flag), .transfer_toward_host_flag(transfer_toward_host_flag), .rdData(rdData),
    .wrStb(wrStb), .wrData(wrData), .rdStb(rdStb)
  );

  task automatic chkV(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkB(input logic [7:0] got, input logic [7:0] exp);
    chkV({8'h00, got}, {8'h00, exp});
  endtask

  // Engine stand-in: seven random result bytes for data commands.
  initial forever begin
    @(negedge clk);
    if (start === 1'b1) begin
      if (kind === CL_XFER || kind === CL_FORMAT) begin
        for (int i = 0; i < 7; i++) begin
          resWr = 1'b1;
          resData = 8'($random(seed));
          expQ.push_back(resData);
          @(negedge clk);
          resWr = 1'b0;
          @(negedge clk);
        end
      end
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
    end
  end

  task automatic cmd(input int n);
    for (int i = 0; i < n; i++) fprd_host_model_i.wrByte(pb[i]);
    repeat (6) @(negedge clk);
  endtask
  task automatic results(input int n, input int nChk, input logic irqOn);
    logic [7:0] b;
    fprd_host_model_i.waitFlags(1'b1);
    if (irqOn) chkV({15'h0, irq}, 16'h1);
    for (int i = 0; i < n; i++) begin
      fprd_host_model_i.rdByte(b);
      if (i < nChk) chkB(b, expQ.pop_front());
    end
    expQ.delete();
    @(negedge clk);
    chkV({13'h0, host_service_request_flag, transfer_toward_host_flag, busy}, 16'h4);
  endtask
  task automatic gate(input logic [15:0] i, input logic [7:0] d);
    idx = i;
    din = d;
    repeat (2) @(negedge clk);
  endtask

  // Main sequence: transfers, faults, seeks, mode commands, then verify and format.
  initial begin
    resetn = 1'b0;
    done = 1'b0;
    resWr = 1'b0;
    resData = 8'h00;
    idx = 16'h0000;
    din = 8'h00;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    chkV({11'h0, host_service_request_flag, transfer_toward_host_flag, busy, irq, fel}, 16'h11);
    chkB(sl, 8'hff);
    for (int w = 0; w < 2; w++) begin
      foreach (pb[i]) pb[i] = 8'($random(seed));
      pb[0] = w ? 8'h05 : 8'h06;
      pb[1] = 8'h00;
      pb[2] = w ? 8'hff : 8'h00;
      pb[5] = 8'h00;
      pb[8] = 8'h01 + 8'($random(seed) & 32'h7e);
      cmd(9);
      chkV({15'h0, busy}, 16'h1);
      chkV({12'h0, kind, xw}, {12'h0, CL_XFER, w[0]});
      results(7, 7, 1'b1);
      chkV({cyl, ds, 6'h0}, {pb[2], 8'h00});
      chkV({sz, sl}, {8'h00, pb[8]});
      chkV(crc, 16'h0080);
      gate({8'h00, pb[8]}, 8'h5a);
      if (w) chkB(dbyte, 8'h00);
      else chkV({15'h0, pass}, 16'h0);
      gate({8'h00, pb[8] - 8'h01}, 8'h5a);
      if (w) chkB(dbyte, 8'h5a);
      else chkV({15'h0, pass}, 16'h1);
    end
    pb[0] = 8'h1f;
    cmd(1);
    chkV({14'h0, irq, busy}, 16'h2);
    pb[0] = 8'h08;
    expQ.push_back(8'h80);
    cmd(1);
    results(2, 1, 1'b0);
    for (int d = 0; d < 2; d++) begin
      pb[0] = d ? 8'hcf : 8'h8f;
      pb[1] = 8'(d);
      pb[2] = 8'($random(seed));
      cmd(3);
      chkV({cyl, 3'h0, d1u, rel, inw, ds},
           {pb[2], 3'h0, d[0], 1'b1, d[0], pb[1][1:0]});
      for (int n = 0; n < 200 && irq !== 1'b1; n++) @(negedge clk);
      chkV({14'h0, irq, busy}, 16'h2);
      pb[0] = 8'h08;
      expQ.push_back(8'h20 | pb[1]);
      cmd(1);
      results(2, 1, 1'b0);
    end
    pb[0] = 8'h07;
    pb[1] = 8'h00;
    cmd(2);
    for (int n = 0; n < 200 && irq !== 1'b1; n++) @(negedge clk);
    chkV({10'h0, kind, ds, busy}, {10'h0, CL_OTHER, 3'h0});
    pb[0] = 8'h08;
    expQ.push_back(8'h20);
    cmd(1);
    results(2, 1, 1'b0);
    pb[0] = 8'h13;
    pb[2] = 8'h40;
    cmd(4);
    chkV({15'h0, fel}, 16'h0);
    pb[0] = 8'h03;
    pb[2] = 8'h20;
    cmd(3);
    chkV({14'h0, fel, busy}, 16'h0);
    for (int k = 1; k < 4; k++) begin
      pb[0] = 8'h12;
      pb[1] = 8'(k << 2);
      cmd(2);
      chkV({14'h0, perp}, 16'(k));
    end
    foreach (pb[i]) pb[i] = 8'($random(seed));
    pb[0] = 8'h96;
    pb[1] = 8'h00;
    pb[5] = 8'h02;
    cmd(9);
    results(7, 7, 1'b1);
    chkV({7'h0, ec, spt}, {8'h01, pb[8]});
    chkV(crc, 16'h0200);
    gate(16'h01ff, 8'h5a);
    chkV({15'h0, pass}, 16'h1);
    pb[0] = 8'h0d;
    pb[2] = 8'h00;
    cmd(6);
    results(7, 7, 1'b1);
    chkB(fill, pb[5]);
    gate(16'h0003, 8'h33);
    chkB(dbyte, pb[5]);
    print_verdict();
  end

  // Watchdog: the whole run needs only a few hundred cycles.
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict();
  end

  task automatic print_verdict();
    miscompares += fprd_host_model_i.stalls;
    if (miscompares == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
endmodule
`default_nettype wire
